// >>> spi_ctrl_pkg.sv
// spi_ctrl_pkg: constants and types of the serial control port
// assumes: included first; shared by the port top and its helpers
`default_nettype none

package spi_ctrl_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // geometry
    localparam int ADDR_W = 14;
    localparam int USER_DEPTH = 16;
    localparam logic [13:0] USER_SPAN = 14'h0010;
    localparam logic [3:0] INSTR_LAST = 4'hF;
    localparam logic [3:0] BYTE_LAST = 4'h7;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [13:0] ADDR_CFG_A = 14'h0000;
    localparam logic [13:0] ADDR_CFG_B = 14'h0001;
    localparam logic [13:0] ADDR_CHIP_TYPE = 14'h0003;
    localparam logic [13:0] ADDR_PROD_LO = 14'h0004;
    localparam logic [13:0] ADDR_PROD_HI = 14'h0005;
    localparam logic [13:0] ADDR_SCRATCH = 14'h000A;
    localparam logic [13:0] ADDR_SPI_REV = 14'h000B;
    localparam logic [13:0] ADDR_VENDOR_LO = 14'h000C;
    localparam logic [13:0] ADDR_VENDOR_HI = 14'h000D;
    localparam logic [13:0] ADDR_IO_UPDATE = 14'h000F;
    localparam logic [13:0] ADDR_USER_BASE = 14'h0010;
    localparam logic [13:0] ADDR_FIRST = 14'h0000;
    localparam logic [13:0] ADDR_TOP = 14'h3A3B;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CFGA_SOFT_RESET = 7;
    localparam int CFGA_LSB_FIRST = 6;
    localparam int CFGA_ASCEND = 5;
    localparam int CFGA_SDO_ACTIVE = 4;
    localparam int CFGA_SDO_MIRROR = 3;
    localparam int CFGA_ASCEND_MIRROR = 2;
    localparam int CFGA_LSB_MIRROR = 1;
    localparam int CFGA_SOFT_MIRROR = 0;
    localparam int CFGB_READ_ACTIVE = 5;
    localparam int IO_UPDATE_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // values after reset and fixed values
    localparam logic [7:0] CFGB_RESET = 8'h00;
    localparam logic [7:0] SCRATCH_RESET = 8'h00;
    localparam logic [7:0] USER_RESET = 8'h00;
    localparam logic [7:0] SPI_REVISION = 8'h01;
    localparam logic [7:0] STARTUP_CYCLES = 8'h10;
    localparam logic PROTOCOL_SPI_LEVEL = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {PH_INSTR, PH_WRITE, PH_READ} phase_t;

    typedef struct packed {
        logic readNotWrite;
        logic unusedTop;
        logic [13:0] addr;
    } instr_t;

    typedef struct packed {
        logic lsbFirst;
        logic ascend;
        logic fourWire;
    } link_cfg_t;

    localparam link_cfg_t CFG_RESET = '{lsbFirst: 1'b0, ascend: 1'b0, fourWire: 1'b0};

endpackage

`default_nettype wire

// >>> sync_bit.sv
// sync_bit: two-flop synchroniser for a single level
// assumes: input is quasi-static relative to clk
`default_nettype none
`timescale 1ns/1ns

module sync_bit (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic async,
    output logic synced
);
    logic stage1_reg;
    logic stage2_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= async;
            stage2_reg <= stage1_reg;
        end
    end

    assign synced = stage2_reg;
endmodule // sync_bit

`default_nettype wire

// >>> active_bank.sv
// active_bank: active copies of the buffered registers
// assumes: buffer is stable for several mclk cycles around copyPulse
`default_nettype none
`timescale 1ns/1ns

module active_bank (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic copyPulse,
    input wire logic [spi_ctrl_pkg::USER_DEPTH*8-1:0] bufferFlat,
    output logic [spi_ctrl_pkg::USER_DEPTH*8-1:0] activeFlat
);
    import spi_ctrl_pkg::*;

    logic [7:0] active_reg [USER_DEPTH];
    logic [7:0] active_next [USER_DEPTH];

    genvar gi;
    generate
        for (gi = 0; gi < USER_DEPTH; gi++) begin : g_entry
            always_comb begin
                active_next[gi] = copyPulse ? bufferFlat[gi*8 +: 8] : active_reg[gi];
            end
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    active_reg[gi] <= USER_RESET;
                end else begin
                    active_reg[gi] <= active_next[gi];
                end
            end
            assign activeFlat[gi*8 +: 8] = active_reg[gi];
        end
    endgenerate
endmodule // active_bank

`default_nettype wire

// >>> serial_control_port_spi_slave.sv
// serial_control_port_spi_slave: spi slave giving a host access to the register map
// assumes: host is spi master, spiClk idle low, link logic clocked by spiClk,
// register map kept in the link domain, active copies in the mclk domain
`default_nettype none
`timescale 1ns/1ns

module serial_control_port_spi_slave #(
    parameter logic [7:0] CHIP_TYPE = 8'h0A,   // arbitrary value
    parameter logic [11:0] PRODUCT_ID = 12'hABC, // arbitrary value
    parameter logic [15:0] VENDOR_ID = 16'h1234  // arbitrary value
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic protocolSelectPin,
    input wire logic spiClk,
    input wire logic chipSelect_n,
    input wire logic sdioIn,
    output logic sdioOut,
    output logic sdioOe_n,
    output logic serialDataOut,
    output logic serialDataOutOe_n,
    output logic spiSelected,
    output logic ioUpdatePulse,
    output spi_ctrl_pkg::link_cfg_t linkCfg,
    output logic [spi_ctrl_pkg::USER_DEPTH*8-1:0] activeRegs
);
    import spi_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // mclk domain: protocol selection at start-up
    logic protoSynced;
    logic [7:0] startCnt_reg;
    logic [7:0] startCnt_next;
    logic spiSel_reg;
    logic spiSel_next;
    logic startDone_reg;
    logic startDone_next;

    sync_bit u_proto_sync (
        .clk(mclk),
        .arst_n(arst_n),
        .async(protocolSelectPin),
        .synced(protoSynced)
    );

    always_comb begin
        startCnt_next = startCnt_reg;
        startDone_next = startDone_reg;
        spiSel_next = spiSel_reg;
        if (!startDone_reg) begin
            startCnt_next = startCnt_reg + 8'h01;
            if (startCnt_reg == STARTUP_CYCLES) begin
                // latched once; nothing but reset reopens it
                startDone_next = 1'b1;
                spiSel_next = (protoSynced == PROTOCOL_SPI_LEVEL);
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            startCnt_reg <= 8'h00;
            startDone_reg <= 1'b0;
            spiSel_reg <= 1'b0;
        end else begin
            startCnt_reg <= startCnt_next;
            startDone_reg <= startDone_next;
            spiSel_reg <= spiSel_next;
        end
    end

    assign spiSelected = spiSel_reg;

    ////////////////////////////////////////////////////////////////////////////
    // link domain: reset and configuration
    // shift engine and read launch are held in reset outside a frame, so they need no edge
    // of spiClk after chip select rises to clean up
    logic linkRst_n;
    assign linkRst_n = arst_n & ~chipSelect_n & spiSel_reg;

    function automatic logic [15:0] rev16(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15-i];
        end
        return r;
    endfunction

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction

    function automatic logic [13:0] stepAddr(input logic [13:0] a, input logic up);
        logic [13:0] r;
        r = a;
        if (up) begin
            r = (a == ADDR_TOP) ? ADDR_FIRST : a + 14'h0001;
        end else begin
            r = (a == ADDR_FIRST) ? ADDR_TOP : a - 14'h0001;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // link domain: shift engine on rising edge
    phase_t phase_reg;
    phase_t phase_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [15:0] shift_reg;
    logic [15:0] shift_next;
    logic [13:0] addr_reg;
    logic [13:0] addr_next;
    link_cfg_t cfg_reg;
    instr_t instrWord;
    logic wrStrobe;
    logic [7:0] wrByte;

    always_comb begin
        phase_next = phase_reg;
        cnt_next = cnt_reg + 4'h1;
        shift_next = {shift_reg[14:0], sdioIn};
        addr_next = addr_reg;
        wrStrobe = 1'b0;
        // bit order applies to instruction and payload alike
        instrWord = cfg_reg.lsbFirst ? rev16(shift_next) : shift_next;
        wrByte = cfg_reg.lsbFirst ? rev8(shift_next[7:0]) : shift_next[7:0];
        case (phase_reg)
            PH_INSTR: begin
                // always a full 16-bit instruction; bit 14 ignored
                if (cnt_reg == INSTR_LAST) begin
                    addr_next = instrWord.addr;
                    phase_next = instrWord.readNotWrite ? PH_READ : PH_WRITE;
                    cnt_next = 4'h0;
                end
            end
            PH_WRITE: begin
                if (cnt_reg == BYTE_LAST) begin
                    wrStrobe = 1'b1;
                    addr_next = stepAddr(addr_reg, cfg_reg.ascend);
                    cnt_next = 4'h0;
                end
            end
            PH_READ: begin
                if (cnt_reg == BYTE_LAST) begin
                    addr_next = stepAddr(addr_reg, cfg_reg.ascend);
                    cnt_next = 4'h0;
                end
            end
            default: begin
                phase_next = PH_INSTR;
                cnt_next = 4'h0;
            end
        endcase
    end

    always_ff @(posedge spiClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            phase_reg <= PH_INSTR;
            cnt_reg <= 4'h0;
            shift_reg <= 16'h0000;
            addr_reg <= 14'h0000;
        end else begin
            phase_reg <= phase_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            addr_reg <= addr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link domain: register map (buffer side)
    link_cfg_t cfg_next;
    logic [7:0] cfgB_reg;
    logic [7:0] cfgB_next;
    logic [7:0] scratch_reg;
    logic [7:0] scratch_next;
    logic ioToggle_reg;
    logic ioToggle_next;
    logic [7:0] userBuf_reg [USER_DEPTH];
    logic [7:0] userBuf_next [USER_DEPTH];
    logic [13:0] userOff;
    logic userHit;
    logic [USER_DEPTH*8-1:0] bufferFlat;

    assign userOff = addr_reg - ADDR_USER_BASE;
    assign userHit = (addr_reg >= ADDR_USER_BASE) && (userOff < USER_SPAN);

    always_comb begin
        cfg_next = cfg_reg;
        cfgB_next = cfgB_reg;
        scratch_next = scratch_reg;
        ioToggle_next = ioToggle_reg;
        if (wrStrobe) begin
            case (addr_reg)
                ADDR_CFG_A: begin
                    // mirrored halves make the byte readable in either bit order
                    if (wrByte[CFGA_SOFT_RESET] | wrByte[CFGA_SOFT_MIRROR]) begin
                        cfg_next = CFG_RESET;
                        cfgB_next = CFGB_RESET;
                    end else begin
                        cfg_next.lsbFirst = wrByte[CFGA_LSB_FIRST] | wrByte[CFGA_LSB_MIRROR];
                        cfg_next.ascend = wrByte[CFGA_ASCEND] | wrByte[CFGA_ASCEND_MIRROR];
                        cfg_next.fourWire = wrByte[CFGA_SDO_ACTIVE] | wrByte[CFGA_SDO_MIRROR];
                    end
                end
                ADDR_CFG_B: cfgB_next = wrByte;
                ADDR_SCRATCH: scratch_next = wrByte;
                ADDR_IO_UPDATE: begin
                    // an event crosses as a toggle; the bit itself never stores
                    if (wrByte[IO_UPDATE_BIT]) begin
                        ioToggle_next = ~ioToggle_reg;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge spiClk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_reg <= CFG_RESET;
            cfgB_reg <= CFGB_RESET;
            scratch_reg <= SCRATCH_RESET;
            ioToggle_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            cfgB_reg <= cfgB_next;
            scratch_reg <= scratch_next;
            ioToggle_reg <= ioToggle_next;
        end
    end

    assign linkCfg = cfg_reg;

    genvar gi;
    generate
        for (gi = 0; gi < USER_DEPTH; gi++) begin : g_buf
            always_comb begin
                userBuf_next[gi] = userBuf_reg[gi];
                if (wrStrobe && userHit && (userOff[3:0] == 4'(gi))) begin
                    userBuf_next[gi] = wrByte;
                end
            end
            always_ff @(posedge spiClk or negedge arst_n) begin
                if (!arst_n) begin
                    userBuf_reg[gi] <= USER_RESET;
                end else begin
                    userBuf_reg[gi] <= userBuf_next[gi];
                end
            end
            assign bufferFlat[gi*8 +: 8] = userBuf_reg[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // link domain: read mux and falling-edge launch
    logic [7:0] readByte;
    logic [2:0] bitSel;
    logic outBit_reg;
    logic outBit_next;
    logic drive_reg;
    logic drive_next;

    always_comb begin
        readByte = 8'h00;
        case (addr_reg)
            ADDR_CFG_A: readByte = {1'b0, cfg_reg.lsbFirst, cfg_reg.ascend, cfg_reg.fourWire,
                                    cfg_reg.fourWire, cfg_reg.ascend, cfg_reg.lsbFirst, 1'b0};
            ADDR_CFG_B: readByte = cfgB_reg;
            ADDR_CHIP_TYPE: readByte = CHIP_TYPE;
            ADDR_PROD_LO: readByte = PRODUCT_ID[7:0];
            ADDR_PROD_HI: readByte = {4'h0, PRODUCT_ID[11:8]};
            ADDR_SCRATCH: readByte = scratch_reg;
            ADDR_SPI_REV: readByte = SPI_REVISION;
            ADDR_VENDOR_LO: readByte = VENDOR_ID[7:0];
            ADDR_VENDOR_HI: readByte = VENDOR_ID[15:8];
            default: begin
                if (userHit) begin
                    readByte = userBuf_reg[userOff[3:0]];
                end
            end
        endcase
    end

    assign bitSel = cfg_reg.lsbFirst ? cnt_reg[2:0] : 3'h7 - cnt_reg[2:0];

    always_comb begin
        outBit_next = readByte[bitSel];
        drive_next = (phase_reg == PH_READ);
    end

    always_ff @(negedge spiClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            outBit_reg <= 1'b0;
            drive_reg <= 1'b0;
        end else begin
            outBit_reg <= outBit_next;
            drive_reg <= drive_next;
        end
    end

    // drive_reg is reset while deselected, so both pins float then
    assign sdioOut = outBit_reg;
    assign serialDataOut = outBit_reg;
    assign sdioOe_n = ~(drive_reg & ~cfg_reg.fourWire);
    assign serialDataOutOe_n = ~(drive_reg & cfg_reg.fourWire);

    ////////////////////////////////////////////////////////////////////////////
    // mclk domain: io update event and active copy
    // the buffer is static for many mclk cycles after the toggle because the
    // next byte needs eight more spiClk edges; the copy relies on that
    logic ioSynced;
    logic ioSeen_reg;
    logic ioSeen_next;
    logic ioPulse_reg;
    logic ioPulse_next;

    sync_bit u_io_sync (
        .clk(mclk),
        .arst_n(arst_n),
        .async(ioToggle_reg),
        .synced(ioSynced)
    );

    always_comb begin
        ioSeen_next = ioSynced;
        ioPulse_next = ioSynced ^ ioSeen_reg;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ioSeen_reg <= 1'b0;
            ioPulse_reg <= 1'b0;
        end else begin
            ioSeen_reg <= ioSeen_next;
            ioPulse_reg <= ioPulse_next;
        end
    end

    assign ioUpdatePulse = ioPulse_reg;

    active_bank u_active (
        .mclk(mclk),
        .arst_n(arst_n),
        .copyPulse(ioPulse_reg),
        .bufferFlat(bufferFlat),
        .activeFlat(activeRegs)
    );
endmodule // serial_control_port_spi_slave

`default_nettype wire

// >>> spi_slave_asserts.sv
// spi_slave_asserts: port-level checks of the serial control port
// assumes: bound to serial_control_port_spi_slave; spiClk idle low between frames
`timescale 1ns/1ns
`default_nettype none

module spi_slave_asserts
    import spi_ctrl_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic protocolSelectPin,
    input wire logic spiClk,
    input wire logic chipSelect_n,
    input wire logic sdioOut,
    input wire logic sdioOe_n,
    input wire logic serialDataOutOe_n,
    input wire logic spiSelected,
    input wire logic ioUpdatePulse,
    input wire spi_ctrl_pkg::link_cfg_t linkCfg,
    input wire logic [spi_ctrl_pkg::USER_DEPTH*8-1:0] activeRegs
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////////////
    // serial clock rises in the current frame, saturating past the instruction
    logic [4:0] riseCount_reg;
    logic [4:0] riseCount_next;

    always_comb begin
        riseCount_next = riseCount_reg + ((riseCount_reg < 5'h11) ? 5'h01 : 5'h00);
    end

    always_ff @(posedge spiClk or posedge chipSelect_n or negedge arst_n) begin
        if (!arst_n || chipSelect_n) begin
            riseCount_reg <= 5'h00;
        end else begin
            riseCount_reg <= riseCount_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_FLOAT_DESELECTED: assert property (chipSelect_n |-> sdioOe_n && serialDataOutOe_n)
        else $error("data pins driven while deselected");
    AST_FOUR_WIRE_OUT: assert property (!serialDataOutOe_n |-> linkCfg.fourWire && sdioOe_n)
        else $error("output pin driven outside 4-wire read");
    AST_THREE_WIRE_OUT: assert property (!sdioOe_n |-> !linkCfg.fourWire && serialDataOutOe_n)
        else $error("data pin driven outside 3-wire read");
    AST_READ_AFTER_INSTR: assert property ((!sdioOe_n || !serialDataOutOe_n) |-> riseCount_reg >= 5'h10)
        else $error("read data before the full instruction");
    AST_LAUNCH_FALLING: assert property (spiClk && $past(spiClk) && !chipSelect_n |-> $stable(sdioOut))
        else $error("read bit moved while serial clock high");
    AST_STRAP_SPI: assert property ($rose(spiSelected) |-> protocolSelectPin == PROTOCOL_SPI_LEVEL)
        else $error("spi chosen against the strap");
    AST_STRAP_HELD: assert property (spiSelected |=> spiSelected)
        else $error("protocol choice dropped without reset");
    AST_UPDATE_ONE_CYCLE: assert property (ioUpdatePulse |=> !ioUpdatePulse)
        else $error("update pulse longer than one cycle");
    AST_ACTIVE_ON_UPDATE: assert property (!$stable(activeRegs) |-> $past(ioUpdatePulse) || $past(ioUpdatePulse, 2))
        else $error("active registers moved without update");
    AST_CFG_QUIET_DESELECT: assert property (chipSelect_n && $past(chipSelect_n) |-> $stable(linkCfg))
        else $error("config changed while deselected");
endmodule // spi_slave_asserts

bind serial_control_port_spi_slave spi_slave_asserts chk (.mclk(mclk), .arst_n(arst_n),
    .protocolSelectPin(protocolSelectPin), .spiClk(spiClk), .chipSelect_n(chipSelect_n),
    .sdioOut(sdioOut), .sdioOe_n(sdioOe_n), .serialDataOutOe_n(serialDataOutOe_n),
    .spiSelected(spiSelected), .ioUpdatePulse(ioUpdatePulse), .linkCfg(linkCfg),
    .activeRegs(activeRegs));

`default_nettype wire

// >>> spi_host_model.sv
// spi_host_model: spi master standing in for the host controller
// assumes: mode 0 at 8 MHz; bench sets lsbFirst and fourWire to match the device
`timescale 1ns/1ns
`default_nettype none

module spi_host_model (
    output logic spiClk,
    output logic chipSelect_n,
    output logic sdioIn,
    input wire logic sdioOut,
    input wire logic sdioOe_n,
    input wire logic serialDataOut,
    input wire logic serialDataOutOe_n
);
    logic lsbFirst = 1'b0;
    logic fourWire = 1'b0;
    logic hostDrive = 1'b0;
    logic hostBit = 1'b0;
    logic floatBit = 1'b0;
    logic pinLevel;
    logic [7:0] rxByte;
    event byteDone;

    initial spiClk = 1'b0;
    initial chipSelect_n = 1'b1;

    // undriven lines toggle so a stale bit never passes for read data
    always @(negedge spiClk) floatBit = ~floatBit;
    assign sdioIn = (sdioOe_n === 1'b0) ? sdioOut : (hostDrive ? hostBit : floatBit);
    assign pinLevel = fourWire ? ((serialDataOutOe_n === 1'b0) ? serialDataOut : floatBit) : sdioIn;

    ////////////////////////////////////////////////////////////////////////////
    task automatic frame(input logic rw, input logic [13:0] addr, input int nBits,
            input logic [127:0] wdata);
        logic [15:0] instr;
        int j;
        instr = {rw, 1'b0, addr};
        chipSelect_n = 1'b0;
        #40;
        for (int i = 0; i < 16 + nBits; i++) begin
            j = (i - 16) % 8;
            hostDrive = !(rw && i >= 16);
            if (i < 16) hostBit = lsbFirst ? instr[i] : instr[15 - i];
            else hostBit = wdata[(i - 16) / 8 * 8 + (lsbFirst ? j : 7 - j)];
            #63 spiClk = 1'b1;
            if (rw && i >= 16) begin
                rxByte[lsbFirst ? j : 7 - j] = pinLevel;
                if (j == 7) -> byteDone;
            end
            #62 spiClk = 1'b0;
        end
        hostDrive = 1'b0;
        #40 chipSelect_n = 1'b1;
        #200;
    endtask

    // clocking with chip select high must leave the device untouched
    task automatic noise(input logic [15:0] pat);
        hostDrive = 1'b1;
        for (int i = 0; i < 16; i++) begin
            hostBit = pat[i];
            #63 spiClk = 1'b1;
            #62 spiClk = 1'b0;
        end
        hostDrive = 1'b0;
    endtask
endmodule // spi_host_model

`default_nettype wire

// >>> serial_control_port_spi_slave_test.sv
// serial_control_port_spi_slave_test: self-checking bench for the spi control port
// assumes: spi_host_model drives the serial side; checker bound separately
`timescale 1ns/1ns
`default_nettype none

module serial_control_port_spi_slave_test;
    import spi_ctrl_pkg::*;

    localparam logic [7:0] TYPE_CODE = 8'h3C; // arbitrary value
    localparam logic [11:0] PROD_CODE = 12'h5A7; // arbitrary value
    localparam logic [15:0] MAKER_CODE = 16'h9E21; // arbitrary value

    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic protocolSelectPin = 1'b0;
    logic spiClk, chipSelect_n, sdioIn, sdioOut, sdioOe_n, serialDataOut, serialDataOutOe_n;
    logic spiSelected, ioUpdatePulse;
    link_cfg_t linkCfg;
    logic [USER_DEPTH*8-1:0] activeRegs;
    logic [USER_DEPTH*8-1:0] bufFlat = {USER_DEPTH{USER_RESET}};
    logic [7:0] expQ[$];
    logic [127:0] actQ[$];
    logic [31:0] rng = 32'h7142;
    logic [127:0] data;
    int errors = 0;
    int testsRun = 0;

    always #5 mclk = ~mclk;

    serial_control_port_spi_slave #(.CHIP_TYPE(TYPE_CODE), .PRODUCT_ID(PROD_CODE),
            .VENDOR_ID(MAKER_CODE)) DUT (.mclk(mclk), .arst_n(arst_n),
        .protocolSelectPin(protocolSelectPin), .spiClk(spiClk), .chipSelect_n(chipSelect_n),
        .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe_n(sdioOe_n), .serialDataOut(serialDataOut),
        .serialDataOutOe_n(serialDataOutOe_n), .spiSelected(spiSelected),
        .ioUpdatePulse(ioUpdatePulse), .linkCfg(linkCfg), .activeRegs(activeRegs));

    spi_host_model host (.spiClk(spiClk), .chipSelect_n(chipSelect_n), .sdioIn(sdioIn),
        .sdioOut(sdioOut), .sdioOe_n(sdioOe_n), .serialDataOut(serialDataOut),
        .serialDataOutOe_n(serialDataOutOe_n));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic close_out();
        $display("mismatches %0d, comparisons %0d", errors, testsRun);
        if (errors == 0 && testsRun > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic tally(input logic ok, input logic [127:0] e, input logic [127:0] g);
        testsRun++;
        if (!ok) begin
            errors++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
        tally(g === e, e, g);
    endtask

    task automatic cmp_regs(input logic [127:0] e, input logic [127:0] g);
        tally(g === e, e, g);
    endtask

    task automatic cmp_cfg(input link_cfg_t e, input link_cfg_t g);
        tally(g === e, e, g);
    endtask

    task automatic cmp_bit(input logic e, input logic g);
        tally(g === e, e, g);
    endtask

    // read notes one expected byte per payload byte before the frame starts
    task automatic rd(input logic [13:0] addr, input int n, input logic [127:0] exp);
        for (int k = 0; k < n; k++) expQ.push_back(exp[8 * k +: 8]);
        host.frame(1'b1, addr, 8 * n, '0);
    endtask

    task automatic wr(input logic [13:0] addr, input int n, input logic [127:0] d);
        host.frame(1'b0, addr, 8 * n, d);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(host.byteDone) begin
        if (expQ.size() > 0) cmp_byte(expQ.pop_front(), host.rxByte);
        else tally(1'b0, '0, host.rxByte);
    end

    always @(posedge mclk) begin
        if (ioUpdatePulse === 1'b1) begin
            repeat (2) @(posedge mclk);
            #1;
            if (actQ.size() > 0) cmp_regs(actQ.pop_front(), activeRegs);
            else tally(1'b0, '0, activeRegs);
        end
    end

    initial begin
        #300000;
        errors++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (30) @(posedge mclk);
        cmp_bit(1'b1, spiSelected);
        data = {TYPE_CODE, PROD_CODE[7:0], 4'h0, PROD_CODE[11:8], 32'h0, SCRATCH_RESET,
            SPI_REVISION, MAKER_CODE[7:0], MAKER_CODE[15:8]};
        rd(ADDR_VENDOR_HI, 11, data);
        wr(ADDR_CFG_A, 1, 8'h3C);
        cmp_cfg('{lsbFirst: 1'b0, ascend: 1'b1, fourWire: 1'b1}, linkCfg);
        host.fourWire = 1'b1;
        rd(ADDR_CFG_A, 1, 8'h3C);
        repeat (32) rng = lfsr(rng);
        data = {96'h0, rng};
        bufFlat[31:0] = rng;
        wr(ADDR_USER_BASE, 4, data);
        rd(ADDR_USER_BASE, 4, data);
        wr(14'h3010, 1, ~data);
        host.frame(1'b0, 14'h0014, 5, 128'hFF);
        host.noise(rng[15:0]);
        rd(14'h0014, 1, 8'h00);
        rd(ADDR_USER_BASE, 1, data);
        actQ.push_back(bufFlat);
        wr(ADDR_IO_UPDATE, 1, 8'h01);
        rd(ADDR_IO_UPDATE, 1, 8'h00);
        wr(ADDR_CFG_A, 1, 8'h66);
        host.lsbFirst = 1'b1;
        host.fourWire = 1'b0;
        rd(ADDR_USER_BASE, 4, data);
        wr(ADDR_CFG_A, 1, 8'h42);
        rd(ADDR_CFG_A, 2, 16'h0042);
        repeat (32) rng = lfsr(rng);
        bufFlat[31:16] = {rng[7:0], rng[15:8]};
        wr(14'h0013, 2, rng[15:0]);
        rd(14'h0013, 2, rng[15:0]);
        // soft reset: symmetric byte, so either bit order sets it
        wr(ADDR_CFG_A, 1, 8'h81);
        cmp_cfg(CFG_RESET, linkCfg);
        host.lsbFirst = 1'b0;
        actQ.push_back(bufFlat);
        wr(ADDR_IO_UPDATE, 1, 8'h01);
        @(posedge mclk);
        arst_n <= 1'b0;
        protocolSelectPin <= 1'b1;
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (30) @(posedge mclk);
        cmp_bit(1'b0, spiSelected);
        protocolSelectPin <= 1'b0;
        repeat (40) @(posedge mclk);
        cmp_bit(1'b0, spiSelected);
        cmp_bit(1'b1, expQ.size() == 0 && actQ.size() == 0);
        close_out();
    end
endmodule // serial_control_port_spi_slave_test

`default_nettype wire
